//--- design/pmb_clock_ctrl.v
// Synthesizer loop filter mode control and glitch-free base clock
// selector, with an APB register slave.
// Assumes crystal_clock and vco_clock are sampled as ordinary inputs
// synchronous to pclk, and running well below half the pclk rate.
//
// The placing of the registers and the APB register port were left to the implementer.
`default_nettype none
`include "pmb_map.vh"

module pmb_clock_ctrl #(
    parameter ADDR_W = 12
) (
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire crystal_clock,
    input wire vco_clock,
    input wire osc_enable_in,
    input wire freq_in_track_tol,
    input wire freq_out_untrack_tol,
    input wire freq_in_lock_tol,
    input wire freq_out_unlock_tol,
    output reg base_clock_out,
    output reg synth_irq,
    output reg synth_enable,
    output reg osc_enable,
    output reg filter_track_mode,
    output reg [3:0] divider_ratio,
    output reg [3:0] range_factor
);

    // Decode codes for the three registers
    localparam [1:0] DEC_NONE = 2'h0;
    localparam [1:0] DEC_CTRL = 2'h1;
    localparam [1:0] DEC_BW = 2'h2;
    localparam [1:0] DEC_PROG = 2'h3;

    // Selector states, one-hot
    localparam [1:0] SEL_RUN = 2'h1;
    localparam [1:0] SEL_SWITCH = 2'h2;

    // Word address decode, shared by read mux and write path
    function [1:0] pmb_decode;
        input [ADDR_W-1:0] addr;
        begin
            if (addr == {{(ADDR_W-10){1'b0}}, `PMB_CTRL_IDX, 2'h0}) begin
                pmb_decode = DEC_CTRL;
            end else if (addr == {{(ADDR_W-10){1'b0}}, `PMB_BW_IDX, 2'h0})
            begin
                pmb_decode = DEC_BW;
            end else if (addr == {{(ADDR_W-10){1'b0}}, `PMB_PROG_IDX,
                                  2'h0}) begin
                pmb_decode = DEC_PROG;
            end else begin
                pmb_decode = DEC_NONE;
            end
        end
    endfunction

    // Control register state
    reg settle_irq_enable; // Interrupt enable, auto mode only
    reg settle_change_flag; // Sticky toggle flag of settled state
    reg synth_power_on; // Synthesizer power switch
    reg base_source_select; // 1 selects VCO, 0 crystal

    // Bandwidth register state
    reg bw_self_control; // 1 = automatic bandwidth control
    reg freq_settled; // Lock indicator from the detector
    reg track_auto; // Detector's own filter mode
    reg track_manual; // Software's filter mode, kept across auto

    // Programming register state
    reg [3:0] mul_field; // Multiplier N
    reg [3:0] range_field; // Linear range factor L

    // Bus handshake helpers
    reg flag_seen; // Flag value handed out by the pending read
    wire [1:0] bus_dec;
    wire setup_phase;
    wire xfer_done;
    wire wr_ctrl;
    wire wr_bw;
    wire wr_prog;
    wire rd_ctrl_done;

    // Derived state
    wire range_zero;
    wire track_now;
    reg next_settled;
    reg next_track_auto;
    reg [31:0] rd_mux;

    // Source selector state
    reg [1:0] sel_state;
    reg active_src; // Source currently feeding the divider
    wire [1:0] src_in;
    reg [1:0] src_d;
    wire [1:0] src_rise;
    reg [1:0] edge_cnt_x; // Crystal edges seen during a switch
    reg [1:0] edge_cnt_v; // VCO edges seen during a switch
    wire x_ready;
    wire v_ready;

    assign bus_dec = pmb_decode(paddr);
    assign setup_phase = psel & ~penable;
    // pready is a flop, so every transfer carries exactly one wait-free
    // access cycle after setup
    assign xfer_done = psel & penable & pready;
    assign wr_ctrl = xfer_done & pwrite & (bus_dec == DEC_CTRL);
    assign wr_bw = xfer_done & pwrite & (bus_dec == DEC_BW);
    assign wr_prog = xfer_done & pwrite & (bus_dec == DEC_PROG);
    assign rd_ctrl_done = xfer_done & ~pwrite & (bus_dec == DEC_CTRL);

    assign range_zero = (range_field == 4'h0);
    // Tracking whenever the filter is not acquiring
    assign track_now = bw_self_control ? track_auto : track_manual;

    // Detector next state, only meaningful in automatic mode
    always @* begin
        next_settled = freq_settled;
        next_track_auto = track_auto;
        if (bw_self_control) begin
            // Set on entering the tight window, clear on leaving the wide
            // one; the gap between them gives hysteresis
            if (freq_in_track_tol) begin
                next_track_auto = 1'b1;
            end else if (freq_out_untrack_tol) begin
                next_track_auto = 1'b0;
            end
            if (freq_in_lock_tol) begin
                next_settled = 1'b1;
            end else if (freq_out_unlock_tol) begin
                next_settled = 1'b0;
            end
        end else begin
            // Manual mode: detector idle, re-entry starts acquiring
            next_settled = 1'b0;
            next_track_auto = 1'b0;
        end
    end

    // Read data mux; reserved bits as the register layout defines
    always @* begin
        rd_mux = 32'h0000_0000;
        case (bus_dec)
            DEC_CTRL: begin
                rd_mux[`PMB_CTRL_IE_BIT] = settle_irq_enable;
                rd_mux[`PMB_CTRL_FLAG_BIT] = settle_change_flag;
                rd_mux[`PMB_CTRL_PON_BIT] = synth_power_on;
                rd_mux[`PMB_CTRL_BCS_BIT] = base_source_select;
                rd_mux[3:0] = `PMB_CTRL_PAD;
            end
            DEC_BW: begin
                rd_mux[`PMB_BW_AUTO_BIT] = bw_self_control;
                rd_mux[`PMB_BW_LOCK_BIT] = freq_settled;
                // Clear while acquiring
                rd_mux[`PMB_BW_TRACK_BIT] = track_now;
            end
            DEC_PROG: begin
                rd_mux[`PMB_PROG_MUL_HI:`PMB_PROG_MUL_LO] = mul_field;
                rd_mux[`PMB_PROG_RNG_HI:`PMB_PROG_RNG_LO] = range_field;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // APB slave: data and error captured in setup, answered next cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            flag_seen <= 1'b0;
        end else if (clk_en) begin
            pready <= setup_phase;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= (bus_dec == DEC_NONE);
                // Remember what the read returns, so a flag raised after
                // this point survives the clear at completion
                flag_seen <= ~pwrite & (bus_dec == DEC_CTRL) &
                             settle_change_flag;
            end else if (xfer_done) begin
                pslverr <= 1'b0;
                flag_seen <= 1'b0;
            end
        end
    end

    // Control register: enable, flag, power and source interlocks
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_irq_enable <= 1'b0;
            settle_change_flag <= 1'b0;
            synth_power_on <= `PMB_PON_RST;
            base_source_select <= 1'b0;
        end else if (clk_en) begin
            // Enable exists only in automatic mode
            if (!bw_self_control) begin
                settle_irq_enable <= 1'b0;
            end else if (wr_ctrl) begin
                settle_irq_enable <= pwdata[`PMB_CTRL_IE_BIT];
            end
            // Toggle sets; a read clears only what it returned; set wins
            if (!bw_self_control) begin
                settle_change_flag <= 1'b0;
            end else if (next_settled != freq_settled) begin
                settle_change_flag <= 1'b1;
            end else if (rd_ctrl_done && flag_seen) begin
                settle_change_flag <= 1'b0;
            end
            if (wr_ctrl) begin
                // Power may drop only while crystal is selected; the
                // check uses the old select, so one write cannot do
                // both
                if (!base_source_select) begin
                    synth_power_on <= pwdata[`PMB_CTRL_PON_BIT];
                end
                // VCO select needs power already on and a valid range;
                // the old power value is used
                base_source_select <= pwdata[`PMB_CTRL_BCS_BIT] &
                                      synth_power_on & ~range_zero;
            end else if (range_zero) begin
                base_source_select <= 1'b0;
            end
        end
    end

    // Bandwidth register and lock detector state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_self_control <= 1'b0;
            freq_settled <= 1'b0;
            track_auto <= 1'b0;
            track_manual <= 1'b0;
        end else if (clk_en) begin
            freq_settled <= next_settled;
            track_auto <= next_track_auto;
            if (wr_bw) begin
                bw_self_control <= pwdata[`PMB_BW_AUTO_BIT];
                // Writable only in manual mode; auto keeps it aside
                // for when manual operation resumes
                if (!bw_self_control) begin
                    track_manual <= pwdata[`PMB_BW_TRACK_BIT];
                end
            end
        end
    end

    // Programming register; multiplier locked while powered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mul_field <= `PMB_MUL_RST;
            range_field <= `PMB_RNG_RST;
        end else if (clk_en) begin
            if (wr_prog) begin
                // Changing N under a running loop would unlock it
                if (!synth_power_on) begin
                    mul_field <= pwdata[`PMB_PROG_MUL_HI:`PMB_PROG_MUL_LO];
                end
                range_field <= pwdata[`PMB_PROG_RNG_HI:`PMB_PROG_RNG_LO];
            end
        end
    end

    // Registered status and analog-facing controls
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synth_irq <= 1'b0;
            synth_enable <= 1'b0;
            osc_enable <= 1'b0;
            filter_track_mode <= 1'b0;
            divider_ratio <= 4'h0;
            range_factor <= 4'h0;
        end else if (clk_en) begin
            // Lock detector flag is the only interrupt source
            synth_irq <= bw_self_control & settle_irq_enable &
                         settle_change_flag;
            // Oscillator enable gates both crystal and synth
            synth_enable <= synth_power_on & ~range_zero &
                            osc_enable_in;
            osc_enable <= osc_enable_in;
            filter_track_mode <= track_now;
            // Zero programs the divider as one
            divider_ratio <= (mul_field == 4'h0) ? 4'h1 : mul_field;
            range_factor <= range_field;
        end
    end

    // Rising edge detect of both sampled source clocks; bit 0 crystal,
    // bit 1 VCO
    assign src_in = {vco_clock, crystal_clock};
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : src_edge
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src_d[g] <= 1'b0;
                end else if (clk_en) begin
                    src_d[g] <= src_in[g];
                end
            end
            assign src_rise[g] = src_in[g] & ~src_d[g];
        end
    endgenerate

    // A stopped VCO would never deliver its edges, so its share of the
    // wait is waived once the synthesizer is disabled
    assign x_ready = (edge_cnt_x == `PMB_SWITCH_EDGES);
    assign v_ready = (edge_cnt_v == `PMB_SWITCH_EDGES) | ~synth_enable;

    // Source transition control and divide-by-two
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_state <= SEL_RUN;
            active_src <= 1'b0;
            edge_cnt_x <= 2'h0;
            edge_cnt_v <= 2'h0;
            base_clock_out <= 1'b0;
        end else if (clk_en) begin
            case (sel_state)
                SEL_RUN: begin
                    if (base_source_select != active_src) begin
                        // Freeze the output while both sources settle
                        sel_state <= SEL_SWITCH;
                        edge_cnt_x <= 2'h0;
                        edge_cnt_v <= 2'h0;
                    end else if (src_rise[active_src]) begin
                        // Halving gives 50 percent duty
                        base_clock_out <= ~base_clock_out;
                    end
                end
                SEL_SWITCH: begin
                    // Output held static here
                    if (src_rise[0] && !x_ready) begin
                        edge_cnt_x <= edge_cnt_x + 2'h1;
                    end
                    if (src_rise[1] && !v_ready) begin
                        edge_cnt_v <= edge_cnt_v + 2'h1;
                    end
                    if (x_ready && v_ready) begin
                        active_src <= base_source_select;
                        sel_state <= SEL_RUN;
                    end
                end
                default: begin
                    sel_state <= SEL_RUN;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- shared/pmb_map.vh
// Register map, field positions, reset values and counts for the
// synthesizer mode and base clock selector.
// Assumes it is included by bare name from the design file.
`ifndef PMB_MAP_VH
`define PMB_MAP_VH

// Register indices; byte address is four times the index
`define PMB_CTRL_IDX 8'h5C
`define PMB_BW_IDX 8'h5D
`define PMB_PROG_IDX 8'h5E

// Control register fields
`define PMB_CTRL_IE_BIT 7
`define PMB_CTRL_FLAG_BIT 6
`define PMB_CTRL_PON_BIT 5
`define PMB_CTRL_BCS_BIT 4
`define PMB_CTRL_PAD 4'hF

// Bandwidth register fields
`define PMB_BW_AUTO_BIT 7
`define PMB_BW_LOCK_BIT 6
`define PMB_BW_TRACK_BIT 5

// Programming register fields
`define PMB_PROG_MUL_HI 7
`define PMB_PROG_MUL_LO 4
`define PMB_PROG_RNG_HI 3
`define PMB_PROG_RNG_LO 0

// Reset values
`define PMB_PON_RST 1'b1
`define PMB_MUL_RST 4'h6
`define PMB_RNG_RST 4'h6

// Source edges to wait for on a base source change
`define PMB_SWITCH_EDGES 2'h3

`endif

//--- tb/pll_mode_and_base_clock_select_tb.sv
// Self-checking bench for the synthesizer mode and base clock selector.
// Assumes the design header and the partner model are compiled alongside.
`default_nettype none
`include "pmb_map.vh"
module pll_mode_and_base_clock_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CTRL = 12'(`PMB_CTRL_IDX * 4);
    localparam logic [11:0] BW = 12'(`PMB_BW_IDX * 4);
    localparam logic [11:0] PROG = 12'(`PMB_PROG_IDX * 4);
    logic pclk = 1'b0, presetn = 1'b0, osc_req = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, base_clock_out, synth_irq, synth_enable, e;
    logic osc_enable, filter_track_mode, osc_enable_in;
    logic [3:0] divider_ratio, range_factor, tol = 4'h0;
    logic [2:0] div = 3'h0; // Crystal is pclk/8, VCO pclk/4
    logic [15:0] base_rises;
    int error_cnt = 0, n_tests = 0;

    always #12.5 pclk = ~pclk;
    always @(posedge pclk) div <= div + 3'h1;

    pmb_clock_ctrl u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_clock(div[2]), .vco_clock(div[1]),
        .osc_enable_in(osc_enable_in), .freq_in_track_tol(tol[0]),
        .freq_out_untrack_tol(tol[1]), .freq_in_lock_tol(tol[2]),
        .freq_out_unlock_tol(tol[3]), .base_clock_out(base_clock_out),
        .synth_irq(synth_irq), .synth_enable(synth_enable),
        .osc_enable(osc_enable), .filter_track_mode(filter_track_mode),
        .divider_ratio(divider_ratio), .range_factor(range_factor));
    pmb_sim_model u_sim (.pclk(pclk), .presetn(presetn), .osc_req(osc_req),
        .base_clock_out(base_clock_out), .osc_enable_in(osc_enable_in),
        .base_rises(base_rises));

    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask

    // One APB transfer; data is taken where pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd_v, output logic er);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        // Hold the request until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        // A missing answer counts as a mismatch
        if (pready !== 1'b1) error_cnt++;
        rd_v = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, r, e);
        chk($sformatf("read %h", a), r, x);
    endtask

    // One-cycle pulse on a tolerance comparator, then let it settle
    task automatic tp(input int i);
        tol[i] <= 1'b1;
        @(posedge pclk);
        tol[i] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    // Base clock rising edges over 160 cycles, after the switch settles
    task automatic meas(input logic [31:0] x);
        logic [15:0] b0;
        repeat (40) @(posedge pclk);
        @(negedge pclk);
        b0 = base_rises;
        repeat (160) @(negedge pclk);
        chk("base rises", 32'(base_rises - b0), x);
        @(posedge pclk);
    endtask

    task automatic conclude;
        $display("Checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog; the full sequence needs about 620 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        conclude;
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(CTRL, 32'h2F);
        rd(BW, 32'h0);
        rd(PROG, 32'h66);
        chk("divider", 32'(divider_ratio), 32'h6);
        apb(1'b0, 12'h17C, 32'h0, r, e);
        chk("unmapped err", 32'(e), 32'h1);
        chk("unmapped data", r, 32'h0);
        apb(1'b0, 12'h171, 32'h0, r, e);
        chk("misaligned err", 32'(e), 32'h1);
        wr(PROG, 32'h35);
        rd(PROG, 32'h65);
        chk("range", 32'(range_factor), 32'h5);
        repeat (20) @(posedge pclk);
        wr(BW, 32'h20);
        rd(BW, 32'h20);
        chk("track", 32'(filter_track_mode), 32'h1);
        repeat (20) @(posedge pclk);
        wr(CTRL, 32'h30);
        rd(CTRL, 32'h3F);
        meas(32'd20);
        wr(CTRL, 32'h0F);
        // Output must stay frozen while the switch waits for its edges
        e = base_clock_out;
        repeat (12) @(posedge pclk);
        chk("base held", 32'(base_clock_out), 32'(e));
        rd(CTRL, 32'h2F);
        meas(32'd10);
        wr(BW, 32'h0);
        wr(CTRL, 32'h0F);
        rd(CTRL, 32'h0F);
        chk("synth on", 32'(synth_enable), 32'h0);
        wr(CTRL, 32'h10);
        rd(CTRL, 32'h0F);
        wr(PROG, 32'h0);
        rd(PROG, 32'h0);
        chk("divider", 32'(divider_ratio), 32'h1);
        wr(CTRL, 32'h30);
        rd(CTRL, 32'h2F);
        wr(CTRL, 32'h30);
        rd(CTRL, 32'h2F);
        chk("synth on", 32'(synth_enable), 32'h0);
        wr(CTRL, 32'h0F);
        wr(PROG, 32'h66);
        wr(CTRL, 32'h20);
        wr(BW, 32'h80);
        wr(CTRL, 32'hA0);
        tp(0);
        rd(BW, 32'hA0);
        chk("track", 32'(filter_track_mode), 32'h1);
        tp(1);
        rd(BW, 32'h80);
        chk("track", 32'(filter_track_mode), 32'h0);
        wr(BW, 32'hA0);
        rd(BW, 32'h80);
        tp(2);
        chk("irq", 32'(synth_irq), 32'h1);
        rd(BW, 32'hC0);
        rd(CTRL, 32'hEF);
        repeat (3) @(posedge pclk);
        chk("irq", 32'(synth_irq), 32'h0);
        rd(CTRL, 32'hAF);
        tp(3);
        rd(BW, 32'h80);
        chk("irq", 32'(synth_irq), 32'h1);
        wr(BW, 32'h0);
        rd(CTRL, 32'h2F);
        tp(2);
        chk("irq", 32'(synth_irq), 32'h0);
        rd(BW, 32'h0);
        osc_req <= 1'b0;
        repeat (4) @(posedge pclk);
        chk("synth on", 32'(synth_enable), 32'h0);
        chk("osc on", 32'(osc_enable), 32'h0);
        osc_req <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("synth on", 32'(synth_enable), 32'h1);
        conclude;
    end
endmodule

bind pmb_clock_ctrl pmb_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_clock(crystal_clock), .vco_clock(vco_clock),
    .osc_enable_in(osc_enable_in), .freq_in_lock_tol(freq_in_lock_tol),
    .freq_out_unlock_tol(freq_out_unlock_tol),
    .base_clock_out(base_clock_out), .synth_irq(synth_irq),
    .synth_enable(synth_enable), .osc_enable(osc_enable),
    .divider_ratio(divider_ratio), .range_factor(range_factor));
`default_nettype wire

//--- tb/pmb_checker.sv
// Port checker for the synthesizer mode and base clock selector.
// Assumes it is bound onto pmb_clock_ctrl and sees only its ports.
`default_nettype none
`include "pmb_map.vh"
module pmb_checker #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic osc_enable_in,
    input wire logic freq_in_lock_tol,
    input wire logic freq_out_unlock_tol,
    input wire logic base_clock_out,
    input wire logic synth_irq,
    input wire logic synth_enable,
    input wire logic osc_enable,
    input wire logic [3:0] divider_ratio,
    input wire logic [3:0] range_factor
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [ADDR_W-1:0] CTRL_A = ADDR_W'(`PMB_CTRL_IDX * 4);
    localparam logic [ADDR_W-1:0] BW_A = ADDR_W'(`PMB_BW_IDX * 4);
    localparam logic [ADDR_W-1:0] PROG_A = ADDR_W'(`PMB_PROG_IDX * 4);
    logic [2:0] q_src; // Cycles since a source clock moved
    logic [2:0] q_tol; // Cycles since a lock input moved
    wire logic rd_done = psel && penable && pready && !pwrite;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Saturating quiet counters; outputs may only move shortly after inputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_src <= 3'h0;
            q_tol <= 3'h0;
        end else begin
            q_src <= ($changed(crystal_clock) || $changed(vco_clock))
                ? 3'h0 : q_src + {2'h0, q_src != 3'h7};
            q_tol <= ($changed(freq_in_lock_tol)
                || $changed(freq_out_unlock_tol))
                ? 3'h0 : q_tol + {2'h0, q_tol != 3'h7};
        end
    end

    AST_OSC_GATE: assert property (
        !osc_enable_in |=> !synth_enable && !osc_enable)
        else $error("synth or oscillator enable stayed on");
    AST_RANGE_ZERO: assert property (
        synth_enable |-> range_factor != 4'h0)
        else $error("synth enabled with range zero");
    AST_MUL_ZERO: assert property (
        $past(presetn) |-> divider_ratio != 4'h0)
        else $error("divider ratio zero");
    AST_BASE_STILL: assert property (
        $changed(base_clock_out) |-> q_src < 3'h4)
        else $error("base clock moved with sources quiet");
    AST_IRQ_CLEAR: assert property (
        rd_done && paddr == CTRL_A && prdata[6]
        |-> ##3 (!synth_irq || q_tol < 3'h6))
        else $error("interrupt not cleared by control read");
    AST_PREADY: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access pulse");
    AST_SLVERR: assert property (
        pready |-> pslverr == !(paddr == CTRL_A || paddr == BW_A
        || paddr == PROG_A))
        else $error("pslverr does not match address map");
    AST_MANUAL_ZERO: assert property (
        rd_done && paddr == BW_A && !prdata[7] |-> !prdata[6])
        else $error("settled flag read set in manual mode");
    AST_PROG_MAP: assert property (
        rd_done && paddr == PROG_A |-> prdata[3:0] == range_factor
        && divider_ratio == (prdata[7:4] == 4'h0 ? 4'h1 : prdata[7:4]))
        else $error("program fields disagree with outputs");
endmodule
`default_nettype wire

//--- tb/pmb_sim_model.sv
// Stand-in for the system module that consumes the base clock.
// Assumes osc_req is driven off the rising edge of pclk.
`default_nettype none
module pmb_sim_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic osc_req,
    input wire logic base_clock_out,
    output var logic osc_enable_in,
    output var logic [15:0] base_rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic base_q; // Last sampled base clock

    // Enable follows the request; base clock edges are only counted
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_enable_in <= 1'b0;
            base_q <= 1'b0;
            base_rises <= 16'h0;
        end else begin
            osc_enable_in <= osc_req;
            base_q <= base_clock_out;
            if (base_clock_out && !base_q) base_rises <= base_rises + 16'h1;
        end
    end
endmodule
`default_nettype wire
